// ===== pkg/ffp_pkg.sv
/*
 * Constants and carrier types for the fast programming command handler.
 * Assumes a single 25 MHz core clock and a synchronous active-high reset.
 */
package ffp_pkg;

	// ---------------------------------------------------------------
	// Mode field codes
	// ---------------------------------------------------------------
	localparam logic [3:0] MODE_CMD  = 4'h0;
	localparam logic [3:0] MODE_A0   = 4'h1;
	localparam logic [3:0] MODE_A1   = 4'h2;
	localparam logic [3:0] MODE_A2   = 4'h3;
	localparam logic [3:0] MODE_A3   = 4'h4;
	localparam logic [3:0] MODE_DATA = 4'h5;

	// ---------------------------------------------------------------
	// Command opcodes (arbitrary neutral encodings)
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_ERASE_ALL        = 8'h01;
	localparam logic [7:0] OP_SET_LOCK         = 8'h02;
	localparam logic [7:0] OP_CLEAR_LOCK       = 8'h03;
	localparam logic [7:0] OP_GET_LOCK         = 8'h04;
	localparam logic [7:0] OP_SET_GP           = 8'h05;
	localparam logic [7:0] OP_CLEAR_GP         = 8'h06;
	localparam logic [7:0] OP_GET_GP           = 8'h07;
	localparam logic [7:0] OP_SET_SECURITY     = 8'h08;
	localparam logic [7:0] OP_WMEM             = 8'h09;
	localparam logic [7:0] OP_GET_VERSION      = 8'h0A;
	localparam logic [7:0] OP_PAGE_WRITE_LOCK  = 8'h0B;
	localparam logic [7:0] OP_ERASE_WRITE_LOCK = 8'h0C;

	// Version value, arbitrary
	localparam logic [15:0] VERSION = 16'h0001;
	localparam int          ADDR_W  = 32;

	// Write request towards the memory system
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0]       data;
	} ffp_wr_t;

endpackage : ffp_pkg

// ===== rtl/ffp_cmd.sv
/*
 * Fast programming command handler: decodes handshakes and keeps lock,
 * general bits and security. Assumes the memory system accepts one write
 * per cycle and the erase pin comes from outside the clock domain.
 */
// Local design decisions: the strobed register port and the address map.
// Function
// - Full erase is dropped entirely while any lock bit is set
// - Full erase is opcode entry then a data phase of zero
// - Set-lock activates each lock bit whose mask bit is one
// - Clear-lock deactivates each lock bit whose mask bit is one
// - Page write and lock variants set the region lock bit
// - Get-lock returns lock mask on one read handshake
// - Set-general activates general bits selected by mask
// - Clear-general deactivates selected general bits, others unchanged
// - Get-general returns general bit mask on one read handshake
// - Set-security with data zero locks out every further command
// - Security clears only by erase pin event after erasing flash
// - Memory write may target any address in the map
// - Memory write auto-increments address; new address phases reload it
// - Get-version supplies the version value on one read handshake
// - New command entry first completes the previous command and flushes
// - On read, drive bus once output enable falls, then assert valid low
`timescale 1ns/1ps
module ffp_cmd
	import ffp_pkg::*;
#(
	parameter int DW     = 16,
	parameter int NLOCK  = 16,
	parameter int NGP    = 8,
	parameter int LREG_W = 4
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Programmer pins
	input  wire logic [3:0]              mode,
	input  wire logic [DW-1:0]           data_in,
	output logic      [DW-1:0]           data_out,
	output logic                         data_oe,
	input  wire logic                    command_strobe_n,
	input  wire logic                    output_enable_n,
	output logic                         data_valid_n,
	output logic                         ready_n,
	input  wire logic                    erase_pin,
	// Memory system side
	output ffp_pkg::ffp_wr_t             mem_wr,
	output logic                         mem_wr_en,
	output logic                         flush_req,
	output logic                         erase_all_req,
	input  wire logic [LREG_W-1:0]       page_region,
	output logic                         port_disabled
);
	import ffp_pkg::*;

	// Elaboration checks: bus width and bit counts must fit the logic
	if (!(DW == 8 || DW == 16)) begin : g_dw_chk
		$error("DW must be 8 or 16");
	end
	if (NLOCK > DW || NGP > DW) begin : g_bits_chk
		$error("bit counts exceed bus width");
	end
	if ((1 << LREG_W) < NLOCK) begin : g_region_chk
		$error("LREG_W too narrow");
	end

	localparam int APH = ADDR_W / DW;

	// ---------------------------------------------------------------
	// Pin synchronisers: three stages, change counted when 2 and 3 agree
	// ---------------------------------------------------------------
	logic [2:0] cs_s_r, oe_s_r, er_s_r;
	logic       cs_r, oe_r, er_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_s_r <= 3'h7;
			oe_s_r <= 3'h7;
			er_s_r <= 3'h0;
			cs_r   <= 1'b1;
			oe_r   <= 1'b1;
			er_r   <= 1'b0;
		end else begin
			cs_s_r <= {cs_s_r[1:0], command_strobe_n};
			oe_s_r <= {oe_s_r[1:0], output_enable_n};
			er_s_r <= {er_s_r[1:0], erase_pin};
			if (cs_s_r[1] == cs_s_r[2]) cs_r <= cs_s_r[2];
			if (oe_s_r[1] == oe_s_r[2]) oe_r <= oe_s_r[2];
			if (er_s_r[1] == er_s_r[2]) er_r <= er_s_r[2];
		end
	end

	// Mode and data are stable while the strobe is low, so no sync needed
	wire cs_fall = cs_s_r[1] == 1'b0 && cs_s_r[2] == 1'b0 && cs_r;
	wire oe_fall = oe_s_r[1] == 1'b0 && oe_s_r[2] == 1'b0 && oe_r;
	wire er_rise = er_s_r[1] && er_s_r[2] && !er_r;

	// ---------------------------------------------------------------
	// Command state
	// ---------------------------------------------------------------
	logic [7:0]         op_r, op_nxt;
	logic [ADDR_W-1:0]  addr_r, addr_nxt;
	logic [NLOCK-1:0]   lock_r, lock_nxt;
	logic [NGP-1:0]     gp_r, gp_nxt;
	logic               sec_r, sec_nxt;
	logic               erased_r, erased_nxt;
	logic [DW-1:0]      dout_r, dout_nxt;
	logic               oe_drv_r, oe_drv_nxt;
	logic               vld_n_r, vld_n_nxt;
	logic               rdy_n_r, rdy_n_nxt;
	ffp_wr_t            wr_r, wr_nxt;
	logic               wr_en_r, wr_en_nxt, flush_r, flush_nxt, erase_r, erase_nxt;

	// Cut a bus word down to a lock mask of NLOCK bits
	function automatic logic [NLOCK-1:0] lmask(input logic [DW-1:0] d);
		lmask = NLOCK'(d);
	endfunction : lmask

	// Next-state: one handshake decoded per strobe fall
	always_comb begin
		op_nxt     = op_r;
		addr_nxt   = addr_r;
		lock_nxt   = lock_r;
		gp_nxt     = gp_r;
		sec_nxt    = sec_r;
		erased_nxt = erased_r;
		dout_nxt   = dout_r;
		oe_drv_nxt = oe_drv_r;
		vld_n_nxt  = vld_n_r;
		rdy_n_nxt  = rdy_n_r;
		wr_nxt     = wr_r;
		wr_en_nxt  = 1'b0;
		flush_nxt  = 1'b0;
		erase_nxt  = 1'b0;
		// Erase pin: wipe flash first, clear security once it is gone
		if (er_rise) begin
			erase_nxt  = 1'b1;
			erased_nxt = 1'b1;
			lock_nxt   = '0;
		end else if (erased_r) begin
			sec_nxt    = 1'b0;
			erased_nxt = 1'b0;
		end
		// Ready follows the strobe; refused while secured
		if (cs_fall && !sec_r) rdy_n_nxt = 1'b0;
		else if (cs_r) rdy_n_nxt = 1'b1;
		if (cs_fall && !sec_r) begin
			unique case (mode)
				MODE_CMD: begin
					// Previous command closes and page buffer flushes
					flush_nxt = 1'b1;
					op_nxt    = data_in[7:0];
				end
				MODE_A0, MODE_A1, MODE_A2, MODE_A3: begin
					// Lowest phase first, each filling its slice
					for (int i = 0; i < APH; i++)
						if (mode - MODE_A0 == 4'(i))
							addr_nxt[i*DW +: DW] = data_in;
				end
				MODE_DATA: begin
					unique case (op_r)
						OP_ERASE_ALL: if (data_in == '0 && lock_r == '0) erase_nxt = 1'b1;
						OP_SET_LOCK: lock_nxt = lock_r | lmask(data_in);
						OP_CLEAR_LOCK: lock_nxt = lock_r & ~lmask(data_in);
						OP_SET_GP: gp_nxt = gp_r | NGP'(data_in);
						OP_CLEAR_GP: gp_nxt = gp_r & ~NGP'(data_in);
						OP_SET_SECURITY: if (data_in == '0) sec_nxt = 1'b1;
						OP_GET_LOCK: dout_nxt = DW'(lock_r);
						OP_GET_GP: dout_nxt = DW'(gp_r);
						OP_GET_VERSION: dout_nxt = DW'(VERSION);
						OP_WMEM, OP_PAGE_WRITE_LOCK, OP_ERASE_WRITE_LOCK: begin
							// Any address, word after word
							wr_nxt    = '{addr: addr_r, data: data_in};
							wr_en_nxt = 1'b1;
							addr_nxt  = addr_r + ADDR_W'(1);
							if (op_r != OP_WMEM)
								lock_nxt[page_region] = 1'b1;
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
		// Read phase: drive bus, then valid; release on output enable high
		if (oe_fall && !sec_r) begin
			oe_drv_nxt = 1'b1;
		end else if (oe_drv_r && vld_n_r && !oe_r) begin
			vld_n_nxt = 1'b0;
		end else if (oe_r) begin
			oe_drv_nxt = 1'b0;
			vld_n_nxt  = 1'b1;
		end
	end

	// Register update
	always_ff @(posedge clk) begin
		if (rst) begin
			op_r     <= 8'h00;
			addr_r   <= '0;
			lock_r   <= '0;
			gp_r     <= '0;
			sec_r    <= 1'b0;
			erased_r <= 1'b0;
			dout_r   <= '0;
			oe_drv_r <= 1'b0;
			vld_n_r  <= 1'b1;
			rdy_n_r  <= 1'b1;
			wr_r     <= '0;
			wr_en_r  <= 1'b0;
			flush_r  <= 1'b0;
			erase_r  <= 1'b0;
		end else begin
			op_r     <= op_nxt;
			addr_r   <= addr_nxt;
			lock_r   <= lock_nxt;
			gp_r     <= gp_nxt;
			sec_r    <= sec_nxt;
			erased_r <= erased_nxt;
			dout_r   <= dout_nxt;
			oe_drv_r <= oe_drv_nxt;
			vld_n_r  <= vld_n_nxt;
			rdy_n_r  <= rdy_n_nxt;
			wr_r     <= wr_nxt;
			wr_en_r  <= wr_en_nxt;
			flush_r  <= flush_nxt;
			erase_r  <= erase_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign data_out      = dout_r;
	assign data_oe       = oe_drv_r;
	assign data_valid_n  = vld_n_r;
	assign ready_n       = rdy_n_r;
	assign mem_wr        = wr_r;
	assign mem_wr_en     = wr_en_r;
	assign flush_req     = flush_r;
	assign erase_all_req = erase_r;
	assign port_disabled = sec_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_drive;
		oe_drv_r && vld_n_r;
	endsequence

	chk_erase_locked: assert property (@(posedge clk) disable iff (rst)
		(cs_fall && mode == MODE_DATA && op_r == OP_ERASE_ALL && lock_r != '0 && !er_rise) |=> !erase_r)
		else $error("erase issued while locked");
	chk_erase_zero: assert property (@(posedge clk) disable iff (rst)
		(cs_fall && !sec_r && mode == MODE_DATA && op_r == OP_ERASE_ALL && data_in == '0 && lock_r == '0) |=> erase_r)
		else $error("full erase not issued");
	chk_lock_set: assert property (@(posedge clk) disable iff (rst)
		(cs_fall && !sec_r && mode == MODE_DATA && op_r == OP_SET_LOCK && !er_rise) |=>
		((lock_r & lmask($past(data_in))) == lmask($past(data_in))))
		else $error("set lock missed bits");
	chk_lock_clr: assert property (@(posedge clk) disable iff (rst)
		(cs_fall && !sec_r && mode == MODE_DATA && op_r == OP_CLEAR_LOCK) |=> ((lock_r & lmask($past(data_in))) == '0))
		else $error("clear lock left bits");
	chk_gp_clr: assert property (@(posedge clk) disable iff (rst)
		(cs_fall && !sec_r && mode == MODE_DATA && op_r == OP_CLEAR_GP) |=> gp_r == ($past(gp_r) & ~NGP'($past(data_in))))
		else $error("clear general wrong");
	chk_sec_block: assert property (@(posedge clk) disable iff (rst)
		(sec_r && !erased_r) |=> (!wr_en_r && $stable(gp_r)))
		else $error("command ran while secured");
	chk_addr_inc: assert property (@(posedge clk) disable iff (rst)
		wr_en_nxt |=> addr_r == $past(addr_r) + ADDR_W'(1) ##0 wr_en_r)
		else $error("address not incremented");
	chk_valid_after: assert property (@(posedge clk) disable iff (rst)
		(s_drive and !oe_r) |=> !vld_n_r)
		else $error("valid not asserted after drive");
	chk_valid_drv: assert property (@(posedge clk) disable iff (rst)
		!vld_n_r |-> oe_drv_r)
		else $error("valid without drive");

endmodule : ffp_cmd

// ===== test/ffp_prog_model.sv
/*
 * Programmer model for the fast programming port: write and read handshakes.
 * Assumes the bench calls its tasks one at a time and ties it to one ffp_cmd.
 */
`timescale 1ns/1ps
module ffp_prog_model
	import ffp_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// Programmer pins
	output logic [3:0]       mode,
	output logic [15:0]      data_in,
	input  wire logic [15:0] data_out,
	input  wire logic        data_oe,
	output logic             command_strobe_n,
	output logic             output_enable_n,
	input  wire logic        data_valid_n,
	input  wire logic        ready_n
);
	logic [15:0] drv_r;
	logic        drv_en;
	int          slow;

	initial begin
		mode = MODE_CMD;
		drv_r = 16'h0000;
		drv_en = 1'b1;
		slow = 0;
		command_strobe_n = 1'b1;
		output_enable_n = 1'b1;
	end

	// Bus level; a released bus shows the inverse of the last value, never a stale copy
	always_comb data_in = (data_oe === 1'b1) ? data_out : (drv_en ? drv_r : ~drv_r);

	// Bounded wait on ready (sel 0) or valid (sel 1)
	task automatic wt(input bit sel, input logic lvl, output bit ok);
		ok = 0;
		for (int i = 0; i < 64 && !ok; i++) begin
			@(posedge clk);
			ok = ((sel ? data_valid_n : ready_n) === lvl);
		end
	endtask : wt

	// Write handshake; mode and data held until ready has come and gone
	task automatic wr(input logic [3:0] m, input logic [15:0] d, output bit ok);
		bit ok2;
		@(posedge clk);
		mode <= m;
		drv_r <= d;
		@(posedge clk);
		command_strobe_n <= 1'b0;
		wt(0, 1'b0, ok);
		command_strobe_n <= 1'b1;
		wt(0, 1'b1, ok2);
		repeat (3 + slow) @(posedge clk); // Strobe high at least 3 cycles
	endtask : wr

	// Read handshake; bus released before output enable falls
	task automatic rd(output bit ok);
		bit ok2;
		@(posedge clk);
		drv_en <= 1'b0;
		@(posedge clk);
		output_enable_n <= 1'b0;
		wt(1, 1'b0, ok);
		output_enable_n <= 1'b1;
		wt(1, 1'b1, ok2);
		ok = ok && ok2;
		drv_en <= 1'b1;
		repeat (3 + slow) @(posedge clk);
	endtask : rd
endmodule : ffp_prog_model

// ===== test/ffp_cmd_tb.sv
/*
 * Self-checking bench for ffp_cmd: programmer model drives, a monitor compares.
 * Assumes the package encodings and NLOCK 16, NGP 8.
 */
`timescale 1ns/1ps
module ffp_cmd_tb;
	import ffp_pkg::*;
	logic        clk, rst, erase_pin, data_oe, data_valid_n, ready_n, vld_q;
	logic        mem_wr_en, flush_req, erase_all_req, port_disabled, cmd_n, oe_n;
	logic [3:0]  mode, page_region;
	logic [15:0] data_in, data_out, e_rd, m, c, d;
	logic [31:0] a;
	ffp_wr_t     mem_wr;
	ffp_wr_t     exp_wr[$];
	logic [15:0] exp_rd[$];
	int          err_total, samples_checked, n_erase, n_flush, n_cmd;
	bit          ok;

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	ffp_cmd dut (.clk(clk), .rst(rst), .mode(mode), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .command_strobe_n(cmd_n), .output_enable_n(oe_n),
		.data_valid_n(data_valid_n), .ready_n(ready_n), .erase_pin(erase_pin), .mem_wr(mem_wr),
		.mem_wr_en(mem_wr_en), .flush_req(flush_req), .erase_all_req(erase_all_req),
		.page_region(page_region), .port_disabled(port_disabled));

	ffp_prog_model prog (.clk(clk), .mode(mode), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .command_strobe_n(cmd_n), .output_enable_n(oe_n),
		.data_valid_n(data_valid_n), .ready_n(ready_n));

	// ---------------------------------------------------------------
	// Compare and report
	// ---------------------------------------------------------------
	task automatic cmp_wr(input ffp_wr_t got, input ffp_wr_t exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_wr

	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic final_report();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// Monitor: oldest note against each result as it appears
	always @(posedge clk) begin
		vld_q <= data_valid_n;
		if (rst === 1'b0) begin
			if (mem_wr_en === 1'b1) begin
				cmp_wr(mem_wr, exp_wr.size() ? exp_wr.pop_front() : ~mem_wr);
			end
			if (vld_q === 1'b1 && data_valid_n === 1'b0) begin
				e_rd = exp_rd.size() ? exp_rd.pop_front() : ~data_out;
				cmp_val((data_oe === 1'b1) ? data_out : ~e_rd, e_rd);
			end
			n_erase += (erase_all_req === 1'b1);
			n_flush += (flush_req === 1'b1);
		end
	end

	// ---------------------------------------------------------------
	// Handshake helpers; a lost handshake ends the run as a mismatch
	// ---------------------------------------------------------------
	task automatic hs(input logic [3:0] md, input logic [15:0] dv);
		prog.wr(md, dv, ok);
		n_cmd += (md == MODE_CMD);
		if (!ok) begin
			err_total++;
			final_report();
		end
	endtask : hs

	task automatic cmd(input logic [7:0] op, input logic [15:0] dv);
		hs(MODE_CMD, {8'h00, op});
		hs(MODE_DATA, dv);
	endtask : cmd

	task automatic get(input logic [7:0] op, input logic [15:0] e);
		cmd(op, 16'h0000);
		exp_rd.push_back(e);
		prog.rd(ok);
		if (!ok) begin
			err_total++;
			final_report();
		end
	endtask : get

	initial begin
		rst = 1'b1;
		erase_pin = 1'b0;
		page_region = 4'h0;
		vld_q = 1'b1;
		void'($urandom(77200));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// Chained memory write, then reload across a 16-bit carry, slow partner
		hs(MODE_CMD, {8'h00, OP_WMEM});
		for (int k = 0; k < 2; k++) begin
			prog.slow = k * 5;
			a = k ? 32'h0000_FFFE : $urandom;
			hs(MODE_A0, a[15:0]);
			hs(MODE_A1, a[31:16]);
			for (int i = 0; i < 3; i++) begin
				d = 16'($urandom);
				exp_wr.push_back(ffp_wr_t'{a + 32'(i), d});
				hs(MODE_DATA, d);
			end
		end
		// Locks, then erase refused while locked or with nonzero data
		m = 16'($urandom) | 16'h0001;
		c = 16'($urandom) & 16'hFFFE;
		cmd(OP_SET_LOCK, m);
		cmd(OP_CLEAR_LOCK, c);
		get(OP_GET_LOCK, m & ~c);
		cmd(OP_ERASE_ALL, 16'h0000);
		cmd(OP_CLEAR_LOCK, 16'hFFFF);
		cmd(OP_ERASE_ALL, 16'h0001);
		cmd(OP_ERASE_ALL, 16'h0000);
		// General bits and version
		m = 16'($urandom);
		c = 16'($urandom);
		cmd(OP_SET_GP, m);
		cmd(OP_CLEAR_GP, c);
		get(OP_GET_GP, {8'h00, m[7:0] & ~c[7:0]});
		get(OP_GET_VERSION, VERSION);
		// Page write and lock: the word lands and the region's lock bit is set
		page_region <= 4'($urandom);
		d = 16'($urandom);
		exp_wr.push_back(ffp_wr_t'{32'h0000_0000, d});
		hs(MODE_CMD, {8'h00, OP_PAGE_WRITE_LOCK});
		hs(MODE_A0, 16'h0000);
		hs(MODE_A1, 16'h0000);
		hs(MODE_DATA, d);
		get(OP_GET_LOCK, 16'h0001 << page_region);
		// Security locks the port out until an erase pin event
		cmd(OP_SET_SECURITY, 16'h0000);
		cmp_val(16'(port_disabled), 16'h0001);
		prog.wr(MODE_CMD, {8'h00, OP_GET_VERSION}, ok);
		cmp_val(16'(ok), 16'h0000);
		// Short pin pulse stands in for the long recovery hold; no timer here
		erase_pin <= 1'b1;
		repeat (8) @(posedge clk);
		erase_pin <= 1'b0;
		repeat (8) @(posedge clk);
		cmp_val(16'(port_disabled), 16'h0000);
		cmp_val(16'(n_erase), 16'h0002);
		get(OP_GET_LOCK, 16'h0000);
		cmp_val(16'(n_flush), 16'(n_cmd));
		// Every noted result must have appeared
		cmp_val(16'(exp_wr.size()), 16'h0000);
		cmp_val(16'(exp_rd.size()), 16'h0000);
		final_report();
	end
endmodule : ffp_cmd_tb
